// >>> rtl/intc_pkg.sv
// Shared constants, types and vector tables of the interrupt controller.
// Assumes a single clock domain and a synchronous active-high reset.
package intc_pkg;

  // Source map: one timer group, two DMA channels, four external pins
  localparam int NSRC = 7;
  localparam int SRC_W = 3;
  localparam int NTMR = 3;
  localparam int NDMA = 2;
  localparam int NEXT = 4;
  localparam int NPAIR = 2;
  localparam logic [SRC_W-1:0] SRC_TMR = 3'h0;
  localparam logic [SRC_W-1:0] SRC_DMA0 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_DMA1 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_EXT0 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 3'h4;
  localparam int EXT_BASE = 3;

  // Priority levels, lower number wins
  localparam int PRIO_W = 3;
  localparam logic [PRIO_W-1:0] DEFAULT_PRIO = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_MASK_RST = 3'h7;

  // Vector types
  localparam int VEC_W = 5;
  localparam logic [VEC_W-1:0] VEC_NMI = 5'h02;
  localparam logic [VEC_W-1:0] VEC_TMR0 = 5'h08;
  localparam logic [VEC_W-1:0] VEC_TMR1 = 5'h12;
  localparam logic [VEC_W-1:0] VEC_TMR2 = 5'h13;
  localparam logic [VEC_W-1:0] VEC_DMA0 = 5'h0a;
  localparam logic [VEC_W-1:0] VEC_DMA1 = 5'h0b;
  localparam logic [VEC_W-1:0] VEC_EXT0 = 5'h0c;
  localparam logic [VEC_W-1:0] VEC_EXT1 = 5'h0d;
  localparam logic [VEC_W-1:0] VEC_EXT2 = 5'h0e;
  localparam logic [VEC_W-1:0] VEC_EXT3 = 5'h0f;
  localparam logic [VEC_W-1:0] VEC_SPURIOUS = 5'h1f;

  // Poll and end-of-service word layout
  localparam int WORD_W = 16;
  localparam int POLL_VALID_BIT = 15;
  localparam int END_KIND_BIT = 15;

  typedef logic [VEC_W-1:0] vec_t;
  typedef logic [PRIO_W-1:0] prio_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK1, ST_GAP, ST_ACK2} ack_state_t;

  // Fixed vector of a source; timers use the lowest pending timer
  function automatic vec_t src_vector(input logic [SRC_W-1:0] src, input logic [NTMR-1:0] tmr);
    vec_t v;
    v = VEC_SPURIOUS;
    case (src)
      3'h0: v = tmr[0] ? VEC_TMR0 : (tmr[1] ? VEC_TMR1 : VEC_TMR2);
      3'h1: v = VEC_DMA0;
      3'h2: v = VEC_DMA1;
      3'h3: v = VEC_EXT0;
      3'h4: v = VEC_EXT1;
      3'h5: v = VEC_EXT2;
      3'h6: v = VEC_EXT3;
      default: v = VEC_SPURIOUS;
    endcase
    return v;
  endfunction

  // Vector type to one-hot source; any timer vector names the timer group
  function automatic logic [NSRC-1:0] vec_to_src(input vec_t v);
    logic [NSRC-1:0] s;
    s = '0;
    case (v)
      VEC_TMR0, VEC_TMR1, VEC_TMR2: s[SRC_TMR] = 1'b1;
      VEC_DMA0: s[SRC_DMA0] = 1'b1;
      VEC_DMA1: s[SRC_DMA1] = 1'b1;
      VEC_EXT0: s[EXT_BASE] = 1'b1;
      VEC_EXT1: s[EXT_BASE+1] = 1'b1;
      VEC_EXT2: s[EXT_BASE+2] = 1'b1;
      VEC_EXT3: s[EXT_BASE+3] = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

endpackage

// >>> rtl/prio_bus_if.sv
// Carrier between the controller core and its priority resolver.
// Assumes both ends sit in the same clock domain; purely combinational.
`timescale 1ns/1ps
interface prio_bus_if;
  logic [intc_pkg::NSRC-1:0] pend;
  logic [intc_pkg::NSRC-1:0] in_svc;
  logic [intc_pkg::NSRC-1:0] special;
  logic [intc_pkg::NSRC-1:0][intc_pkg::PRIO_W-1:0] prio;
  logic [intc_pkg::PRIO_W-1:0] prio_mask;
  logic win_valid;
  logic [intc_pkg::SRC_W-1:0] win_idx;
  logic top_valid;
  logic [intc_pkg::SRC_W-1:0] top_idx;

  modport ctl (output pend, in_svc, special, prio, prio_mask, input win_valid, win_idx, top_valid, top_idx);
  modport res (input pend, in_svc, special, prio, prio_mask, output win_valid, win_idx, top_valid, top_idx);
endinterface

// >>> rtl/ext_detect.sv
// Edge or level detection of the four external request pins.
// Assumes the pins are already synchronous to i_clk.
`timescale 1ns/1ps
module ext_detect
  import intc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and configuration
  input wire logic [intc_pkg::NEXT-1:0] i_pin,
  input wire logic [intc_pkg::NEXT-1:0] i_level,
  input wire logic [intc_pkg::NEXT-1:0] i_enable,
  input wire logic [intc_pkg::NEXT-1:0] i_take,
  // Requests to the resolver
  output logic [intc_pkg::NEXT-1:0] o_req
);
  import intc_pkg::*;

  typedef struct packed {
    logic [NEXT-1:0] armed;
  } det_t;

  det_t st_ff;
  det_t nxt_st;

  // Starts disarmed so a pin high out of reset is not a false edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.armed = ~i_pin | (st_ff.armed & ~i_take);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Active high; level mode needs no rearm
  assign o_req = i_pin & (i_level | st_ff.armed) & i_enable;

  genvar g;
  for (g = 0; g < NEXT; g++) begin : g_chk
    AST_EDGE_NO_REPEAT: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_level[g] && i_take[g] && i_pin[g]) ##1 i_pin[g] |-> !o_req[g])
      else $error("edge input requested again without going low");
  end
endmodule

// >>> rtl/prio_resolve.sv
// Priority resolution with in-service blocking and special nesting.
// Assumes masked pending bits and in-service state from the core.
`timescale 1ns/1ps
module prio_resolve
  import intc_pkg::*;
(
  // Resolver side of the carrier
  prio_bus_if.res b
);
  import intc_pkg::*;

  // Key is level then fixed source order, so ties resolve by index
  logic [NSRC-1:0][PRIO_W+SRC_W-1:0] key;
  logic [NSRC-1:0] elig;

  genvar s;
  for (s = 0; s < NSRC; s++) begin : g_src
    // Local per source so each process owns its whole variable
    logic blk;
    assign key[s] = {b.prio[s], SRC_W'(s)};
    always_comb begin
      blk = 1'b0;
      for (int t = 0; t < NSRC; t++) begin
        if (b.in_svc[t] && ((key[t] < key[s]) || (t == s && !b.special[s]))) begin
          blk = 1'b1;
        end
      end
    end
    assign elig[s] = b.pend[s] & ~blk & (b.prio[s] <= b.prio_mask);
  end

  always_comb begin
    logic [PRIO_W+SRC_W-1:0] best;
    logic [PRIO_W+SRC_W-1:0] best_is;
    best = '1;
    best_is = '1;
    b.win_valid = 1'b0;
    b.win_idx = '0;
    b.top_valid = 1'b0;
    b.top_idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (elig[i] && key[i] < best) begin
        best = key[i];
        b.win_valid = 1'b1;
        b.win_idx = SRC_W'(i);
      end
      if (b.in_svc[i] && key[i] < best_is) begin
        best_is = key[i];
        b.top_valid = 1'b1;
        b.top_idx = SRC_W'(i);
      end
    end
  end
endmodule

// >>> rtl/nested_priority_interrupt_controller.sv
// Master-mode nested priority interrupt controller core.
// Assumes one clock, sync inputs, and a processor issuing one-cycle strobes.
`timescale 1ns/1ps

// Summary of operation
// - Non-maskable input always requests; four external pins have configurable roles.
// - Pins zero and one may be cascade inputs; pins two and three acknowledge them.
// - Cascaded acknowledge runs two cycles; external vector captured on the second.
// - Internal sources behave the same whatever the external pin mode.
// - In-service source blocks all lower-priority sources, and itself unless special nested.
// - In-service bit stays set until an end-of-service command clears it.
// - Special nesting is enabled by the special nesting select bit of pin zero or one.
// - Special nesting accepts repeat pin requests while in service, still setting the bit.
// - Poll word bit 15 flags a pending request, bits 0-4 its vector type.
// - Reading the poll word sets the winner's in-service bit like an acknowledge.
// - Poll status word gives the same data and changes no in-service bit.
// - Each source has a 3-bit level, lower wins, preset after reset.
// - Equal levels are resolved by a fixed source order.
// - Nonspecific end-of-service clears the highest-priority in-service bit.
// - Specific end-of-service clears only the bit named by the vector type.
// - External inputs are active high, each edge or level by its trigger bit.
// - Edge input high after acknowledge stays quiet until sampled low once.
// - Level input held high keeps requesting.
// - Fixed internal vectors, also in poll words; acknowledging a cascade or special-nested pin takes the external one.
// - End kind select one means nonspecific, zero means specific.
// - Trigger select one means level, zero means edge.
// - Cascade select one puts the pin pair in cascade, zero direct.
module nested_priority_interrupt_controller
  import intc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic [intc_pkg::NSRC-1:0] i_mask,
  input wire logic [intc_pkg::PRIO_W-1:0] i_prio_mask,
  input wire logic [intc_pkg::NEXT-1:0] i_trigger_select_bit,
  input wire logic [intc_pkg::NPAIR-1:0] i_cascade_select,
  input wire logic [intc_pkg::NPAIR-1:0] i_special_nesting_select,
  input wire logic i_prio_wr,
  input wire logic [intc_pkg::SRC_W-1:0] i_prio_sel,
  input wire logic [intc_pkg::PRIO_W-1:0] i_prio_val,
  // Request sources
  input wire logic i_nmi,
  input wire logic [intc_pkg::NTMR-1:0] i_tmr_req,
  input wire logic [intc_pkg::NDMA-1:0] i_dma_req,
  input wire logic [intc_pkg::NEXT-1:0] i_ext_pin,
  // Processor side
  input wire logic i_ack,
  input wire logic i_poll_rd,
  input wire logic i_poll_status_rd,
  input wire logic i_end_of_service_command,
  input wire logic [intc_pkg::WORD_W-1:0] i_end_word,
  output logic o_int_req,
  output logic o_nmi_req,
  output logic [intc_pkg::VEC_W-1:0] o_vec,
  output logic o_vec_valid,
  output logic [intc_pkg::WORD_W-1:0] o_poll_word,
  output logic o_poll_valid,
  output logic [intc_pkg::NSRC-1:0] o_in_service,
  // Cascade acknowledge on pins two and three
  input wire logic [intc_pkg::VEC_W-1:0] i_ext_vec,
  output logic [intc_pkg::NPAIR-1:0] o_pair_ack_n,
  output logic [intc_pkg::NPAIR-1:0] o_pair_ack_oe
);
  import intc_pkg::*;

  typedef struct packed {
    logic [NSRC-1:0] is;
    logic [NSRC-1:0][PRIO_W-1:0] prio;
    logic [NTMR-1:0] tmr_req;
    logic [NDMA-1:0] dma_req;
    logic nmi_prev;
    logic nmi_pend;
    ack_state_t st;
    logic pair;
    vec_t vec;
    logic vec_valid;
    logic [WORD_W-1:0] poll;
    logic poll_valid;
    logic [NPAIR-1:0] pair_ack;
  } ctl_t;

  localparam ctl_t CTL_RST = '{is: '0, prio: {NSRC{DEFAULT_PRIO}}, tmr_req: '0, dma_req: '0,
    nmi_prev: 1'b0, nmi_pend: 1'b0, st: ST_IDLE, pair: 1'b0, vec: '0, vec_valid: 1'b0,
    poll: '0, poll_valid: 1'b0, pair_ack: '0};

  ctl_t st_ff;
  ctl_t nxt_st;

  prio_bus_if rb ();

  logic [NPAIR-1:0] pair_ext;
  logic [NEXT-1:0] ext_en;
  logic [NEXT-1:0] ext_req;
  logic [NEXT-1:0] ext_take;
  logic [NSRC-1:0] take;
  logic [NTMR-1:0] tmr_low;
  vec_t win_vec;
  logic win_pair;
  logic [WORD_W-1:0] poll_word;
  logic [NSRC-1:0] spec_clr;

  assign spec_clr = vec_to_src(i_end_word[VEC_W-1:0]);
  // Special nesting also uses the pair hardware and external vectors
  assign pair_ext = i_cascade_select | i_special_nesting_select;
  assign ext_en = {~pair_ext, {NPAIR{1'b1}}};
  assign ext_take = take[EXT_BASE +: NEXT];

  ext_detect u_det (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_pin),
    .i_level(i_trigger_select_bit),
    .i_enable(ext_en),
    .i_take(ext_take),
    .o_req(ext_req)
  );

  // Request from the pin is relied on to stand until acknowledge
  assign rb.pend = {ext_req, st_ff.dma_req, |st_ff.tmr_req} & ~i_mask;
  assign rb.in_svc = st_ff.is;
  assign rb.special = {{(NEXT-NPAIR){1'b0}}, i_special_nesting_select, {EXT_BASE{1'b0}}};
  assign rb.prio = st_ff.prio;
  assign rb.prio_mask = i_prio_mask;

  prio_resolve u_res (
    .b(rb)
  );

  assign tmr_low = st_ff.tmr_req & (~st_ff.tmr_req + NTMR'(1));
  assign win_vec = src_vector(rb.win_idx, st_ff.tmr_req);
  assign win_pair = (rb.win_idx == SRC_EXT0 && pair_ext[0]) || (rb.win_idx == SRC_EXT1 && pair_ext[1]);

  always_comb begin
    poll_word = '0;
    poll_word[POLL_VALID_BIT] = rb.win_valid;
    poll_word[VEC_W-1:0] = rb.win_valid ? win_vec : '0;
  end

  always_comb begin
    logic grant;
    grant = 1'b0;
    take = '0;
    nxt_st = st_ff;
    nxt_st.nmi_prev = i_nmi;
    nxt_st.vec_valid = 1'b0;
    nxt_st.poll_valid = 1'b0;
    nxt_st.pair_ack = '0;
    if (i_prio_wr && i_prio_sel < SRC_W'(NSRC)) begin
      nxt_st.prio[i_prio_sel] = i_prio_val;
    end
    // Clears first so that a set in the same cycle wins
    if (i_end_of_service_command) begin
      if (i_end_word[END_KIND_BIT]) begin
        if (rb.top_valid) begin
          nxt_st.is[rb.top_idx] = 1'b0;
        end
      end else begin
        nxt_st.is = st_ff.is & ~spec_clr;
      end
    end
    if (i_poll_rd || i_poll_status_rd) begin
      nxt_st.poll = poll_word;
      nxt_st.poll_valid = 1'b1;
    end
    if (i_poll_rd && rb.win_valid) begin
      grant = 1'b1;
    end
    case (st_ff.st)
      ST_IDLE: begin
        if (i_ack) begin
          if (st_ff.nmi_pend) begin
            nxt_st.nmi_pend = 1'b0;
            nxt_st.vec = VEC_NMI;
            nxt_st.vec_valid = 1'b1;
          end else if (rb.win_valid) begin
            grant = 1'b1;
            if (win_pair) begin
              nxt_st.pair = rb.win_idx[0] ^ SRC_EXT0[0];
              nxt_st.pair_ack[rb.win_idx[0] ^ SRC_EXT0[0]] = 1'b1;
              nxt_st.st = ST_ACK1;
            end else begin
              nxt_st.vec = win_vec;
              nxt_st.vec_valid = 1'b1;
            end
          end else begin
            nxt_st.vec = VEC_SPURIOUS;
            nxt_st.vec_valid = 1'b1;
          end
        end
      end
      ST_ACK1: begin
        nxt_st.st = ST_GAP;
      end
      ST_GAP: begin
        nxt_st.pair_ack[st_ff.pair] = 1'b1;
        nxt_st.st = ST_ACK2;
      end
      ST_ACK2: begin
        nxt_st.vec = i_ext_vec;
        nxt_st.vec_valid = 1'b1;
        nxt_st.st = ST_IDLE;
      end
      default: begin
        nxt_st.st = ST_IDLE;
      end
    endcase
    if (grant) begin
      nxt_st.is[rb.win_idx] = 1'b1;
      take[rb.win_idx] = 1'b1;
    end
    if (take[SRC_TMR]) begin
      nxt_st.tmr_req = st_ff.tmr_req & ~tmr_low;
    end
    if (take[SRC_DMA0]) begin
      nxt_st.dma_req[0] = 1'b0;
    end
    if (take[SRC_DMA1]) begin
      nxt_st.dma_req[1] = 1'b0;
    end
    nxt_st.tmr_req = nxt_st.tmr_req | i_tmr_req;
    nxt_st.dma_req = nxt_st.dma_req | i_dma_req;
    if (i_nmi && !st_ff.nmi_prev) begin
      nxt_st.nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= CTL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_int_req = rb.win_valid;
  assign o_nmi_req = st_ff.nmi_pend;
  assign o_vec = st_ff.vec;
  assign o_vec_valid = st_ff.vec_valid;
  assign o_poll_word = st_ff.poll;
  assign o_poll_valid = st_ff.poll_valid;
  assign o_in_service = st_ff.is;
  assign o_pair_ack_n = ~st_ff.pair_ack;
  assign o_pair_ack_oe = pair_ext;

  // Checks
  logic quiet_is;
  assign quiet_is = !i_ack && !i_poll_rd;

  AST_NMI_UNMASKED: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_nmi && !st_ff.nmi_prev && !i_ack) |=> o_nmi_req)
    else $error("nmi edge not raised");

  AST_ACK_PIN_TWO_CYCLES: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_ff.st == ST_IDLE && i_ack && !st_ff.nmi_pend && rb.win_valid && win_pair)
    |=> !(&o_pair_ack_n) ##1 (&o_pair_ack_n) ##1 !(&o_pair_ack_n) ##1 o_vec_valid && o_vec == $past(i_ext_vec))
    else $error("cascade acknowledge sequence wrong");

  AST_DIRECT_VECTOR: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_ff.st == ST_IDLE && i_ack && !st_ff.nmi_pend && rb.win_valid && !win_pair)
    |=> o_vec_valid && o_vec == $past(win_vec))
    else $error("internal vector not delivered");

  AST_SELF_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    rb.win_valid && st_ff.is[rb.win_idx] |-> rb.special[rb.win_idx])
    else $error("in-service source granted again");

  AST_LOWER_BLOCKED: assert property (@(posedge i_clk) disable iff (i_rst)
    rb.win_valid && rb.top_valid
    |-> ({st_ff.prio[rb.win_idx], rb.win_idx} < {st_ff.prio[rb.top_idx], rb.top_idx}
      || (rb.win_idx == rb.top_idx && rb.special[rb.win_idx])) && (rb.prio[rb.win_idx] <= i_prio_mask))
    else $error("request raised below in-service level");

  AST_POLL_SETS_IS: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_poll_rd && rb.win_valid) |=> o_in_service[$past(rb.win_idx)] && o_poll_word[POLL_VALID_BIT])
    else $error("poll read did not set in-service");

  AST_POLL_STATUS_PURE: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_poll_status_rd && quiet_is && !i_end_of_service_command)
    |=> $stable(o_in_service) && o_poll_word == $past(poll_word))
    else $error("poll status changed state");

  AST_NSPEC_END: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_end_of_service_command && i_end_word[END_KIND_BIT] && rb.top_valid && quiet_is)
    |=> !o_in_service[$past(rb.top_idx)])
    else $error("nonspecific end missed top bit");

  AST_SPEC_END: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_end_of_service_command && !i_end_word[END_KIND_BIT] && quiet_is)
    |=> o_in_service == ($past(o_in_service) & ~$past(spec_clr)))
    else $error("specific end cleared wrong bits");

  COV_CASCADE: cover property (@(posedge i_clk) disable iff (i_rst) st_ff.st == ST_ACK2);
  COV_NESTED: cover property (@(posedge i_clk) disable iff (i_rst) $countones(st_ff.is) >= 2);
  COV_POLL: cover property (@(posedge i_clk) disable iff (i_rst) i_poll_rd && rb.win_valid);
  COV_SPECIAL: cover property (@(posedge i_clk) disable iff (i_rst)
    rb.win_valid && st_ff.is[rb.win_idx]);
endmodule

// >>> sim/ext_cascade_model.sv
// Behavioural external cascaded controller hung on pair zero.
// Assumes the acknowledge line pulses low once per acknowledge cycle, synchronous to i_clk.
`timescale 1ns/1ps
module ext_cascade_model #(
  parameter logic [4:0] VEC = 5'h15
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request and acknowledge
  input wire logic i_raise,
  input wire logic i_ack_n,
  output logic o_req,
  output logic [4:0] o_vec,
  output logic [1:0] o_acks
);
  logic [1:0] cnt_ff;
  assign o_acks = cnt_ff;
  // Inverse outside the second cycle, so a stale sample cannot match
  assign o_vec = (!i_ack_n && cnt_ff == 2'h1) ? VEC : ~VEC;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_req <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (i_raise) begin
      o_req <= 1'b1;
      cnt_ff <= 2'h0;
    end else if (!i_ack_n) begin
      o_req <= 1'b0;
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule

// >>> sim/nested_priority_interrupt_controller_tb_top.sv
// Self-checking bench of the interrupt controller with an external cascade model.
// Assumes the controller's timing as handed over: one-cycle strobes, answers one cycle on.
`timescale 1ns/1ps
module nested_priority_interrupt_controller_tb_top;
  import intc_pkg::*;
  typedef struct packed {logic [2:0] tmr; logic [1:0] dma; logic [3:0] ext; logic [4:0] vec; logic [6:0] isr;} row_t;
  localparam logic [4:0] MDL_VEC = 5'h15;
  logic i_clk, i_rst, i_prio_wr, i_nmi, i_ack, i_poll_rd, i_poll_status_rd, i_eos, mdl_raise, mdl_req;
  logic int_req, nmi_req, vec_valid, poll_valid;
  logic [6:0] mask, isr;
  logic [2:0] pmask, psel, pval, tmr;
  logic [3:0] trig, ext_tb, pin;
  logic [1:0] casc, spec, dma, ack_n, ack_oe, acks;
  logic [15:0] eword, poll_word;
  logic [4:0] ext_vec, vec;
  int fails = 0;
  int checks = 0;
  row_t rows[9] = '{'{3'h1, 2'h0, 4'h0, 5'h08, 7'h01}, '{3'h2, 2'h0, 4'h0, 5'h12, 7'h01},
    '{3'h4, 2'h0, 4'h0, 5'h13, 7'h01}, '{3'h0, 2'h1, 4'h0, 5'h0a, 7'h02}, '{3'h0, 2'h2, 4'h0, 5'h0b, 7'h04},
    '{3'h0, 2'h0, 4'h1, 5'h0c, 7'h08}, '{3'h0, 2'h0, 4'h2, 5'h0d, 7'h10}, '{3'h0, 2'h0, 4'h4, 5'h0e, 7'h20},
    '{3'h0, 2'h0, 4'h8, 5'h0f, 7'h40}};

  // Shared pins resolved from the acknowledge enables
  assign pin[0] = (casc[0] | spec[0]) ? mdl_req : ext_tb[0];
  assign pin[1] = ext_tb[1];
  assign pin[2] = ack_oe[0] ? ack_n[0] : ext_tb[2];
  assign pin[3] = ack_oe[1] ? ack_n[1] : ext_tb[3];

  nested_priority_interrupt_controller i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_mask(mask), .i_prio_mask(pmask),
    .i_trigger_select_bit(trig), .i_cascade_select(casc), .i_special_nesting_select(spec), .i_prio_wr(i_prio_wr),
    .i_prio_sel(psel), .i_prio_val(pval), .i_nmi(i_nmi), .i_tmr_req(tmr), .i_dma_req(dma), .i_ext_pin(pin),
    .i_ack(i_ack), .i_poll_rd(i_poll_rd), .i_poll_status_rd(i_poll_status_rd), .i_end_of_service_command(i_eos),
    .i_end_word(eword), .o_int_req(int_req), .o_nmi_req(nmi_req), .o_vec(vec), .o_vec_valid(vec_valid),
    .o_poll_word(poll_word), .o_poll_valid(poll_valid), .o_in_service(isr), .i_ext_vec(ext_vec),
    .o_pair_ack_n(ack_n), .o_pair_ack_oe(ack_oe));

  ext_cascade_model #(.VEC(MDL_VEC)) u_mdl (.i_clk(i_clk), .i_rst(i_rst), .i_raise(mdl_raise), .i_ack_n(ack_n[0]),
    .o_req(mdl_req), .o_vec(ext_vec), .o_acks(acks));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait on the answer; a miss shows up as a mismatch
  task automatic ack(input logic [4:0] exp);
    i_ack = 1'b1;
    tick();
    i_ack = 1'b0;
    for (int n = 0; n < 8 && vec_valid !== 1'b1; n++) tick();
    chk("vec_valid", 16'h1, {15'h0, vec_valid});
    chk("vec", {11'h0, exp}, {11'h0, vec});
  endtask

  task automatic poll(input logic st);
    i_poll_status_rd = st;
    i_poll_rd = !st;
    tick();
    chk("poll_valid", 16'h1, {15'h0, poll_valid});
    i_poll_status_rd = 1'b0;
    i_poll_rd = 1'b0;
    tick();
  endtask

  task automatic eos(input logic [15:0] w);
    eword = w;
    i_eos = 1'b1;
    tick();
    i_eos = 1'b0;
    tick();
  endtask

  task automatic req(input logic [2:0] t, input logic [1:0] d);
    tmr = t;
    dma = d;
    tick();
    tmr = 3'h0;
    dma = 2'h0;
    tick();
  endtask

  task automatic setprio(input logic [2:0] s, input logic [2:0] v);
    psel = s;
    pval = v;
    i_prio_wr = 1'b1;
    tick();
    i_prio_wr = 1'b0;
    tick();
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    print_verdict();
  end

  initial begin
    {i_prio_wr, i_nmi, i_ack, i_poll_rd, i_poll_status_rd, i_eos, mdl_raise} = '0;
    {mask, trig, casc, spec, psel, pval, tmr, dma, ext_tb, eword} = '0;
    pmask = 3'h7;
    i_rst = 1'b1;
    repeat (20) tick();
    i_rst = 1'b0;
    tick();
    chk("reset isr", 16'h0, {9'h0, isr});
    chk("reset ack_n", 16'h3, {14'h0, ack_n});
    chk("reset int_req", 16'h0, {15'h0, int_req});
    mask = 7'h7f;
    i_nmi = 1'b1;
    tick();
    tick();
    chk("nmi_req", 16'h1, {15'h0, nmi_req});
    ack(VEC_NMI);
    i_nmi = 1'b0;
    mask = 7'h00;
    $display("test reset and nmi done");
    foreach (rows[k]) begin
      ext_tb = rows[k].ext;
      req(rows[k].tmr, rows[k].dma);
      ack(rows[k].vec);
      chk("row isr", {9'h0, rows[k].isr}, {9'h0, isr});
      ext_tb = 4'h0;
      eos(16'h8000);
      chk("row clear", 16'h0, {9'h0, isr});
    end
    $display("test fixed vectors done");
    req(3'h1, 2'h1);
    poll(1'b1);
    chk("status word", 16'h8008, poll_word);
    chk("status isr", 16'h0, {9'h0, isr});
    poll(1'b0);
    chk("poll word", 16'h8008, poll_word);
    chk("poll isr", 16'h1, {9'h0, isr});
    eos(16'h8000);
    poll(1'b0);
    chk("poll word", 16'h800a, poll_word);
    eos(16'h000a);
    chk("specific isr", 16'h0, {9'h0, isr});
    setprio(3'h2, 3'h2);
    setprio(3'h1, 3'h5);
    req(3'h0, 2'h1);
    poll(1'b0);
    req(3'h0, 2'h2);
    chk("nest int_req", 16'h1, {15'h0, int_req});
    poll(1'b0);
    chk("nest word", 16'h800b, poll_word);
    eos(16'h8000);
    chk("nonspecific isr", 16'h2, {9'h0, isr});
    eos(16'h000a);
    pmask = 3'h4;
    req(3'h0, 2'h1);
    chk("prio mask", 16'h0, {15'h0, int_req});
    pmask = 3'h7;
    tick();
    poll(1'b0);
    chk("unmasked", 16'h800a, poll_word);
    eos(16'h8000);
    req(3'h0, 2'h2);
    poll(1'b0);
    req(3'h0, 2'h3);
    chk("blocked", 16'h0, {15'h0, int_req});
    eos(16'h000b);
    chk("unblocked", 16'h1, {15'h0, int_req});
    ack(VEC_DMA1);
    eos(16'h8000);
    ack(VEC_DMA0);
    eos(16'h8000);
    chk("prio isr", 16'h0, {9'h0, isr});
    $display("test priority and poll done");
    ext_tb[1] = 1'b1;
    tick();
    tick();
    ack(VEC_EXT1);
    eos(16'h8000);
    chk("edge held", 16'h0, {15'h0, int_req});
    ext_tb[1] = 1'b0;
    tick();
    ext_tb[1] = 1'b1;
    tick();
    tick();
    chk("edge rearm", 16'h1, {15'h0, int_req});
    ack(VEC_EXT1);
    eos(16'h8000);
    trig[1] = 1'b1;
    tick();
    ack(VEC_EXT1);
    eos(16'h8000);
    chk("level held", 16'h1, {15'h0, int_req});
    ext_tb[1] = 1'b0;
    trig[1] = 1'b0;
    tick();
    $display("test trigger modes done");
    casc[0] = 1'b1;
    mdl_raise = 1'b1;
    tick();
    mdl_raise = 1'b0;
    tick();
    chk("ack_oe", 16'h1, {14'h0, ack_oe});
    ack(MDL_VEC);
    chk("ack count", 16'h2, {14'h0, acks});
    chk("cascade isr", 16'h8, {9'h0, isr});
    eos(16'h8000);
    req(3'h1, 2'h0);
    ack(VEC_TMR0);
    eos(16'h8000);
    casc[0] = 1'b0;
    spec[0] = 1'b1;
    $display("test cascade done");
    for (int n = 0; n < 2; n++) begin
      mdl_raise = 1'b1;
      tick();
      mdl_raise = 1'b0;
      tick();
      chk("special int_req", 16'h1, {15'h0, int_req});
      ack(MDL_VEC);
      chk("special isr", 16'h8, {9'h0, isr});
    end
    ext_tb[1] = 1'b1;
    tick();
    tick();
    chk("lower inhibited", 16'h0, {15'h0, int_req});
    $display("test special nesting done");
    i_rst = 1'b1;
    tick();
    tick();
    i_rst = 1'b0;
    spec = 2'h0;
    tick();
    chk("rerun isr", 16'h0, {9'h0, isr});
    chk("rerun no false edge", 16'h0, {15'h0, int_req});
    req(3'h0, 2'h3);
    poll(1'b1);
    chk("rerun prio", 16'h800a, poll_word);
    mask = 7'h06;
    ext_tb[1] = 1'b0;
    casc = 2'h2;
    ext_tb[3] = 1'b1;
    tick();
    chk("pair one oe", 16'h2, {14'h0, ack_oe});
    chk("ack pin ignored", 16'h0, {15'h0, int_req});
    ext_tb[1] = 1'b1;
    tick();
    i_ack = 1'b1;
    tick();
    i_ack = 1'b0;
    chk("pair one ack_n", 16'h1, {14'h0, ack_n});
    chk("pair one isr", 16'h10, {9'h0, isr});
    repeat (3) tick();
    chk("pair one vec_valid", 16'h1, {15'h0, vec_valid});
    $display("test reset and pair one done");
    print_verdict();
  end
endmodule
